// *** hw/ecvd_pkg.sv ***
/*
 * Package of the exception classing and vector dispatch unit: register
 * offsets, machine state layout, vector offsets, causes and carriers.
 * Assumes a 32-bit register port with byte addresses on aligned words.
 */
package ecvd_pkg;

	localparam int          ECVD_AW        = 8;
	localparam int          ECVD_DW        = 32;
	localparam int          ECVD_PC_W      = 32;

	localparam logic [7:0]  ADDR_MSTATE    = 8'h00;
	localparam logic [7:0]  ADDR_SAVED_RA  = 8'h04;
	localparam logic [7:0]  ADDR_SAVED_MS  = 8'h08;
	localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
	localparam logic [7:0]  ADDR_MASK      = 8'h10;
	localparam logic [7:0]  ADDR_INFO      = 8'h14;

	localparam logic [31:0] OFS_SYS_RESET  = 32'h0000_0100;
	localparam logic [31:0] OFS_MCHECK     = 32'h0000_0200;
	localparam logic [31:0] OFS_DATA_FAULT = 32'h0000_0300;
	localparam logic [31:0] OFS_FETCH      = 32'h0000_0400;
	localparam logic [31:0] OFS_EXT_IRQ    = 32'h0000_0500;
	localparam logic [31:0] OFS_ALIGN      = 32'h0000_0600;
	localparam logic [31:0] VEC_BASE_HIGH  = 32'hFFF0_0000;
	localparam logic [31:0] VEC_BASE_LOW   = 32'h0000_0000;

	// Machine state field positions, low bit first.
	localparam int          MS_REC_BIT     = 0;
	localparam int          MS_USER_BIT    = 1;
	localparam int          MS_EIE_BIT     = 2;
	localparam int          MS_MCE_BIT     = 3;
	localparam int          MS_VPS_BIT     = 4;
	localparam int          MS_W           = 5;
	localparam logic [4:0]  MS_RESET       = 5'h10;

	// Status and mask: one bit per cause, then checkstop.
	localparam int          STAT_W         = 7;
	localparam int          STAT_CHK_BIT   = 6;
	localparam logic [6:0]  STAT_RESET     = 7'h00;

	typedef enum logic [2:0] {
		CS_NONE,
		CS_SYS_RESET,
		CS_MCHECK,
		CS_DATA_FAULT,
		CS_FETCH_FAULT,
		CS_EXT_IRQ,
		CS_ALIGN
	} ecvd_cause_t;

	typedef struct packed {
		logic sys_reset;
		logic mcheck;
		logic ext_irq;
		logic corrupt;
	} ecvd_pins_t;

	typedef struct packed {
		logic [31:0] vector;
		ecvd_cause_t cause;
		logic        async;
		logic        precise;
	} ecvd_take_t;

endpackage

// *** hw/ecvd_exception_unit.sv ***
/*
 * Exception classing and vector dispatch unit with its register port.
 * Assumes the pipeline presents at most one faulting instruction at a
 * time, oldest first, and raises older_done_in once every earlier
 * instruction has completed. Error and interrupt pins are asynchronous.
 * A write to the machine state or saved registers in a cycle that takes
 * an exception is lost, since the take wins. With ALIGN_TRAP_EN at 0
 * alignment faults are never acknowledged and the pipeline must carry
 * out such accesses itself.
 */
// Contract
// RQ1: Each exception is classed sync or async and precise or imprecise, reset and machine check being async unmaskable, the external request async maskable.
// RQ2: Pipeline faults are synchronous, pin events are asynchronous.
// RQ3: The vector is the cause offset placed in the region chosen by the prefix select bit.
// RQ4: System reset goes to offset 00100 and may come from any source.
// RQ5: A system reset that corrupted state clears the saved recoverable flag.
// RQ6: Machine check, raised by the error pin, goes to offset 00200.
// RQ7: A machine check while its enable is 0 enters checkstop instead.
// RQ8: A machine check that corrupted state clears the saved recoverable flag.
// RQ9: A failed data access goes to offset 00300.
// RQ10: A failed instruction fetch goes to offset 00400.
// RQ11: The external request is taken at 00500 only while pending and enabled.
// RQ12: An alignment failure may go to 00600 or be done correctly instead.
// RQ13: Exceptions are taken in program order after older instructions finish; system reset and machine check are taken without waiting for older_done_in.
// RQ14: Taking saves address and state and fetches the vector in supervisor mode.
// RQ15: Pending async events are taken reset first, then machine check, then external.
`timescale 1ns/10ps

module ecvd_exception_unit
	import ecvd_pkg::*;
#(
	parameter bit ALIGN_TRAP_EN = 1'b1
) (
	// Clock and reset.
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_in,
	// Error and interrupt pins.
	input  wire ecvd_pins_t           ext_pins_in,
	// Pipeline side.
	input  wire logic                 fault_valid_in,
	input  wire ecvd_cause_t          fault_kind_in,
	input  wire logic [ECVD_PC_W-1:0] fault_pc_in,
	input  wire logic [ECVD_PC_W-1:0] next_pc_in,
	input  wire logic                 older_done_in,
	output logic                      fault_ack_out,
	output logic                      take_valid_out,
	output ecvd_take_t                take_out,
	output logic                      supervisor_out,
	output logic                      checkstop_out,
	// Register port.
	input  wire logic [ECVD_AW-1:0]   addr_in,
	input  wire logic [ECVD_DW-1:0]   wdata_in,
	input  wire logic                 wr_in,
	input  wire logic                 rd_in,
	output logic [ECVD_DW-1:0]        rdata_out,
	output logic                      irq_out
);

	function automatic logic [31:0] vec_offset(input ecvd_cause_t c);
		case (c)
			CS_SYS_RESET:   vec_offset = OFS_SYS_RESET;
			CS_MCHECK:      vec_offset = OFS_MCHECK;
			CS_DATA_FAULT:  vec_offset = OFS_DATA_FAULT;
			CS_FETCH_FAULT: vec_offset = OFS_FETCH;
			CS_EXT_IRQ:     vec_offset = OFS_EXT_IRQ;
			CS_ALIGN:       vec_offset = OFS_ALIGN;
			default:        vec_offset = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic is_async(input ecvd_cause_t c);
		is_async = (c == CS_SYS_RESET) || (c == CS_MCHECK) ||
			(c == CS_EXT_IRQ);
	endfunction

	logic [3:0]           meta_reg;
	logic [3:0]           sync_reg;
	logic [3:0]           prev_reg;
	logic                 sr_pend_reg;
	logic                 mc_pend_reg;
	logic                 chk_reg;
	logic [MS_W-1:0]      ms_reg;
	logic [ECVD_PC_W-1:0] saved_ra_reg;
	logic [MS_W-1:0]      saved_ms_reg;
	logic [STAT_W-1:0]    stat_reg;
	logic [STAT_W-1:0]    mask_reg;
	logic [ECVD_DW-1:0]   rdata_reg;
	logic                 take_valid_reg;
	ecvd_take_t           take_reg;
	logic                 irq_reg;

	ecvd_pins_t           pins_s;
	ecvd_pins_t           pins_p;
	logic                 sr_rise;
	logic                 mc_rise;
	logic                 ms_vps;
	logic                 ms_mce;
	logic                 ms_eie;
	logic                 take_sr;
	logic                 take_mc;
	logic                 take_sync;
	logic                 take_ext;
	logic                 take_any;
	logic                 sync_ok;
	logic                 chk_enter;
	ecvd_cause_t          cause;
	logic [31:0]          vec_base;
	logic [31:0]          vector;
	logic                 corrupt;
	logic [MS_W-1:0]      saved_ms_next;
	logic [MS_W-1:0]      ms_next;
	logic [ECVD_PC_W-1:0] saved_ra_next;
	logic [STAT_W-1:0]    stat_ev;
	logic [STAT_W-1:0]    stat_next;
	logic [ECVD_DW-1:0]   rdata_next;
	logic                 wr_ms;
	logic                 rd_stat;
	logic                 wr_saved_ra;
	logic                 wr_saved_ms;
	logic                 wr_mask;
	logic [STAT_W-1:0]    mask_next;
	logic                 irq_next;

	// Pins pass two flip-flops; sync_reg and its delayed copy prev_reg are looked at.
	assign pins_s  = ecvd_pins_t'(sync_reg);
	assign pins_p  = ecvd_pins_t'(prev_reg);
	assign sr_rise = pins_s.sys_reset & ~pins_p.sys_reset;   // [RQ2] [RQ4]
	assign mc_rise = pins_s.mcheck & ~pins_p.mcheck;         // [RQ2] [RQ6]
	// Corruption is a level that must still stand at the take edge.
	assign corrupt = pins_s.corrupt;

	assign ms_vps = ms_reg[MS_VPS_BIT];
	assign ms_mce = ms_reg[MS_MCE_BIT];
	assign ms_eie = ms_reg[MS_EIE_BIT];

	// Fixed priority among the async sources; the others stay pending.
	assign take_sr   = sr_pend_reg & ~chk_reg;                   // [RQ15]
	assign chk_enter = ~take_sr & mc_pend_reg & ~ms_mce
		& ~chk_reg;                                              // [RQ7]
	assign take_mc   = ~take_sr & mc_pend_reg & ms_mce
		& ~chk_reg;                                              // [RQ15]
	assign sync_ok   = fault_valid_in & older_done_in &
		((fault_kind_in == CS_DATA_FAULT) ||
		 (fault_kind_in == CS_FETCH_FAULT) ||
		 ((fault_kind_in == CS_ALIGN) && ALIGN_TRAP_EN));        // [RQ12]
	// An older instruction's fault goes before the external request.
	assign take_sync = ~take_sr & ~mc_pend_reg & ~chk_reg
		& sync_ok;                                               // [RQ13]
	// The request is a level; clearing the enable on a take stops a re-take.
	assign take_ext  = ~take_sr & ~mc_pend_reg & ~chk_reg & ~sync_ok
		& pins_s.ext_irq & ms_eie & older_done_in;      // [RQ11] [RQ15]
	assign take_any  = take_sr | take_mc | take_sync | take_ext;
	assign fault_ack_out = take_sync;

	assign cause = take_sr   ? CS_SYS_RESET :
		take_mc   ? CS_MCHECK :
		take_sync ? fault_kind_in :
		take_ext  ? CS_EXT_IRQ : CS_NONE;          // [RQ9] [RQ10] [RQ2]

	// The prefix select bit picks the high or the low vector region.
	assign vec_base = ms_vps ? VEC_BASE_HIGH : VEC_BASE_LOW;   // [RQ3]
	assign vector   = vec_base | vec_offset(cause);   // [RQ4] [RQ6] [RQ11]

	// Corruption at reset or machine check clears the saved flag.
	// Saved registers stay writable so a handler can restore them.
	always_comb begin
		saved_ms_next = saved_ms_reg;
		saved_ra_next = saved_ra_reg;
		if (take_any) begin
			saved_ms_next = ms_reg;                               // [RQ14]
			saved_ra_next = take_sync ? fault_pc_in : next_pc_in; // [RQ14]
			if ((take_sr | take_mc) & corrupt) begin
				saved_ms_next[MS_REC_BIT] = 1'b0;           // [RQ5] [RQ8]
			end
		end else if (wr_saved_ms) begin
			saved_ms_next = wdata_in[MS_W-1:0];
		end else if (wr_saved_ra) begin
			saved_ra_next = wdata_in;
		end
	end

	// Register port write decodes.
	assign wr_ms       = wr_in && (addr_in == ADDR_MSTATE);
	assign wr_saved_ra = wr_in && (addr_in == ADDR_SAVED_RA);
	assign wr_saved_ms = wr_in && (addr_in == ADDR_SAVED_MS);
	assign wr_mask     = wr_in && (addr_in == ADDR_MASK);
	assign mask_next   = wr_mask ? wdata_in[STAT_W-1:0] : mask_reg;

	// A take leaves user mode, masks the external request and marks the
	// live state unrecoverable until the handler has saved the context.
	always_comb begin
		ms_next = ms_reg;
		if (take_any) begin
			ms_next[MS_USER_BIT] = 1'b0;                          // [RQ14]
			ms_next[MS_EIE_BIT]  = 1'b0;
			ms_next[MS_REC_BIT]  = 1'b0;
			if (take_mc) begin
				ms_next[MS_MCE_BIT] = 1'b0;
			end
		end else if (wr_ms) begin
			ms_next = wdata_in[MS_W-1:0];
		end
	end

	// Status: a read clears, a new event in the same cycle wins.
	always_comb begin
		stat_ev = '0;
		if (take_any) begin
			stat_ev[3'(cause) - 3'd1] = 1'b1;
		end
		stat_ev[STAT_CHK_BIT] = chk_enter;
	end
	assign rd_stat   = rd_in && (addr_in == ADDR_STATUS);
	assign stat_next = (rd_stat ? '0 : stat_reg) | stat_ev;
	// The level request comes from a flip-flop, free of decode glitches.
	assign irq_next  = |(stat_next & mask_next);

	// Idle and unmapped reads give zero, so data stand only in the answer.
	always_comb begin
		rdata_next = '0;
		if (rd_in) begin
			case (addr_in)
				ADDR_MSTATE:   rdata_next = 32'(ms_reg);
				ADDR_SAVED_RA: rdata_next = saved_ra_reg;
				ADDR_SAVED_MS: rdata_next = 32'(saved_ms_reg);
				ADDR_STATUS:   rdata_next = 32'(stat_reg);
				ADDR_MASK:     rdata_next = 32'(mask_reg);
				ADDR_INFO:     rdata_next = {28'h0000000, sr_pend_reg,
					mc_pend_reg, pins_s.ext_irq, chk_reg};
				default:       rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			meta_reg <= 4'h0;
			sync_reg <= 4'h0;
			prev_reg <= 4'h0;
		end else begin
			meta_reg <= ext_pins_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Pending sources: set wins over the clear by taking.
	// A new rise in the cycle of a take is kept, so no edge is lost.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sr_pend_reg <= 1'b0;
			mc_pend_reg <= 1'b0;
			chk_reg     <= 1'b0;
		end else begin
			sr_pend_reg <= sr_rise | (sr_pend_reg & ~take_sr);
			mc_pend_reg <= mc_rise
				| (mc_pend_reg & ~take_mc & ~chk_enter);
			chk_reg     <= chk_reg | chk_enter;                   // [RQ7]
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ms_reg       <= MS_RESET;
			saved_ra_reg <= '0;
			saved_ms_reg <= '0;
			stat_reg     <= STAT_RESET;
			mask_reg     <= STAT_RESET;
			rdata_reg    <= '0;
			irq_reg      <= 1'b0;
		end else begin
			ms_reg       <= ms_next;
			saved_ra_reg <= saved_ra_next;
			saved_ms_reg <= saved_ms_next;
			stat_reg     <= stat_next;
			rdata_reg    <= rdata_next;
			mask_reg     <= mask_next;
			irq_reg      <= irq_next;
		end
	end

	// The take record holds until the next take, for a late fetch.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			take_valid_reg <= 1'b0;
			take_reg       <= '0;
		end else begin
			take_valid_reg   <= take_any;
			if (take_any) begin
				take_reg.vector  <= vector;                       // [RQ14]
				take_reg.cause   <= cause;
				take_reg.async   <= is_async(cause);              // [RQ1]
				take_reg.precise <= ~(take_sr | take_mc);         // [RQ1]
			end
		end
	end

	assign take_valid_out = take_valid_reg;
	assign take_out       = take_reg;
	assign supervisor_out = ~ms_reg[MS_USER_BIT];
	assign checkstop_out  = chk_reg;
	assign rdata_out      = rdata_reg;
	assign irq_out        = irq_reg;

endmodule

// *** sim/ecvd_unit_properties.sv ***
/* Port checker of the exception dispatch unit.
   Assumes it is bound to every ecvd_exception_unit. */
`timescale 1ns/10ps
module ecvd_unit_props
	import ecvd_pkg::*;
(
	// Clock and reset.
	input wire logic               clk_sys_in,
	input wire logic               rst_in,
	// Watched ports.
	input wire logic               fault_valid_in,
	input wire logic               older_done_in,
	input wire logic               fault_ack_out,
	input wire logic               take_valid_out,
	input wire ecvd_take_t         take_out,
	input wire logic               supervisor_out,
	input wire logic               checkstop_out,
	input wire logic               rd_in,
	input wire logic [ECVD_DW-1:0] rdata_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	ecvd_cause_t c;
	assign c = take_out.cause;

	ack_order_a:
	assert property (fault_ack_out |-> fault_valid_in && older_done_in)
		else $error("fault acked before older work done");
	ack_take_a:
	assert property (fault_ack_out |=> take_valid_out && !take_out.async)
		else $error("acked fault not taken as synchronous");
	take_super_a:
	assert property (take_valid_out |-> supervisor_out)
		else $error("take without supervisor mode");
	stop_sticky_a:
	assert property (checkstop_out |=> checkstop_out)
		else $error("checkstop left without reset");
	stop_quiet_a:
	assert property (checkstop_out |-> !take_valid_out && !fault_ack_out)
		else $error("exception taken in checkstop");
	vec_place_a:
	assert property (take_valid_out |-> take_out.vector[19:0] ==
		{9'h000, c, 8'h00} && take_out.vector[31:20] inside {12'hFFF, 12'h000})
		else $error("vector does not match cause");
	async_class_a:
	assert property (take_valid_out |-> take_out.async ==
		(c inside {CS_SYS_RESET, CS_MCHECK, CS_EXT_IRQ}))
		else $error("wrong async class");
	precise_class_a:
	assert property (take_valid_out |-> take_out.precise ==
		!(c inside {CS_SYS_RESET, CS_MCHECK}))
		else $error("wrong precise class");
	read_idle_a:
	assert property (!rd_in |=> rdata_out == 32'h0)
		else $error("read data outside read answer");
endmodule

bind ecvd_exception_unit ecvd_unit_props u_props (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.fault_valid_in(fault_valid_in), .older_done_in(older_done_in),
	.fault_ack_out(fault_ack_out), .take_valid_out(take_valid_out),
	.take_out(take_out), .supervisor_out(supervisor_out),
	.checkstop_out(checkstop_out), .rd_in(rd_in), .rdata_out(rdata_out)
);

// *** sim/ecvd_pipe_model.sv ***
/* Pipeline and pin source model for the dispatch unit.
   Assumes one caller of its tasks at a time. */
`timescale 1ns/10ps
module ecvd_pipe_model
	import ecvd_pkg::*;
(
	// Clock.
	input  wire logic  clk_sys_in,
	// Toward the unit.
	input  wire logic  fault_ack_in,
	output ecvd_pins_t pins_out,
	output logic       fault_valid_out,
	output ecvd_cause_t fault_kind_out,
	output logic [31:0] fault_pc_out,
	output logic [31:0] next_pc_out,
	output logic       older_done_out
);
	// Only the pins and fault_valid_out idle at start; the fault fields and
	// older_done_out are first set by a fault, before anything can read them.
	initial begin
		pins_out = '0;
		fault_valid_out = 1'b0;
	end
	task pin(input ecvd_pins_t v);
		@(posedge clk_sys_in);
		pins_out <= v;
	endtask
	// Holds the fault until acked or 20 further falling edges pass; older work finishes after lag cycles.
	task fault(input ecvd_cause_t k, input logic [31:0] pc,
		input int lag, output logic got);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		fault_valid_out <= 1'b1;
		fault_kind_out <= k;
		fault_pc_out <= pc;
		older_done_out <= 1'b0;
		repeat (lag) @(posedge clk_sys_in);
		older_done_out <= 1'b1;
		@(negedge clk_sys_in);
		while (fault_ack_in !== 1'b1 && n < 20) begin
			@(negedge clk_sys_in);
			n++;
		end
		got = fault_ack_in === 1'b1;
		@(posedge clk_sys_in);
		fault_valid_out <= 1'b0;
		fault_kind_out <= CS_NONE;
		fault_pc_out <= ~pc;
		next_pc_out <= pc + 32'h4;
	endtask
endmodule

// *** sim/test_exception_class_vector_dispatch.sv ***
/* Self-checking bench of the exception dispatch unit.
   Assumes the pipeline model and the bound checker. */
`timescale 1ns/10ps
module test_exception_class_vector_dispatch;
	import ecvd_pkg::*;
	logic        clk_sys_in, rst_in, wr_in, rd_in, fv, od, ack, tv;
	logic        sup, cs, irq, got;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in, fpc, npc, rdata, base;
	ecvd_pins_t  pins;
	ecvd_cause_t fk;
	ecvd_take_t  tko;
	int          errors, num_checks;
	ecvd_cause_t kinds [3] = '{CS_DATA_FAULT, CS_FETCH_FAULT, CS_ALIGN};

	ecvd_exception_unit dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.ext_pins_in(pins), .fault_valid_in(fv), .fault_kind_in(fk),
		.fault_pc_in(fpc), .next_pc_in(npc), .older_done_in(od),
		.fault_ack_out(ack), .take_valid_out(tv), .take_out(tko),
		.supervisor_out(sup), .checkstop_out(cs), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata), .irq_out(irq));
	ecvd_pipe_model pm (.clk_sys_in(clk_sys_in), .fault_ack_in(ack),
		.pins_out(pins), .fault_valid_out(fv), .fault_kind_out(fk),
		.fault_pc_out(fpc), .next_pc_out(npc), .older_done_out(od));

	task end_sim;
		if (errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (e !== g) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		cmp("rdata", e, rdata);
	endtask
	task tk(input ecvd_cause_t c);
		int n;
		n = 0;
		@(negedge clk_sys_in);
		while (tv !== 1'b1 && n < 40) begin
			@(negedge clk_sys_in);
			n++;
		end
		cmp("take", 32'h1, tv);
		cmp("cause", c, tko.cause);
		cmp("vector", base | {21'h0, c, 8'h00}, tko.vector);
		cmp("async", c inside {CS_SYS_RESET, CS_MCHECK, CS_EXT_IRQ},
			tko.async);
		cmp("precise", !(c inside {CS_SYS_RESET, CS_MCHECK}),
			tko.precise);
		cmp("super", 32'h1, sup);
	endtask

	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		#200000;
		errors++;
		end_sim;
	end
	initial begin
		{rst_in, wr_in, rd_in} = 3'b100;
		{errors, num_checks} = 0;
		base = VEC_BASE_HIGH;
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		rd(ADDR_MSTATE, {27'h0, MS_RESET});
		rd(8'h40, 32'h0);
		cmp("super", 32'h1, sup);
		foreach (kinds[i]) begin
			pm.fault(kinds[i], 32'h0000_4000 + 32'(i * 16), 2, got);
			cmp("ack", 32'h1, got);
			tk(kinds[i]);
			rd(ADDR_SAVED_RA, 32'h0000_4000 + 32'(i * 16));
		end
		wr(ADDR_MSTATE, 32'h0);
		base = VEC_BASE_LOW;
		pm.fault(CS_DATA_FAULT, 32'h0000_5000, 1, got);
		tk(CS_DATA_FAULT);
		rd(ADDR_STATUS, 32'h2C);
		rd(ADDR_STATUS, 32'h0);
		base = VEC_BASE_HIGH;
		wr(ADDR_MASK, 32'h10);
		wr(ADDR_MSTATE, 32'h10);
		pm.pin(4'b0010);
		repeat (8) @(posedge clk_sys_in);
		rd(ADDR_STATUS, 32'h0);
		wr(ADDR_MSTATE, 32'h14);
		tk(CS_EXT_IRQ);
		pm.pin(4'b0000);
		repeat (2) @(negedge clk_sys_in);
		cmp("irq", 32'h1, irq);
		rd(ADDR_STATUS, 32'h10);
		cmp("irq", 32'h0, irq);
		wr(ADDR_MSTATE, 32'h19);
		pm.pin(4'b1000);
		tk(CS_SYS_RESET);
		pm.pin(4'b0000);
		rd(ADDR_SAVED_MS, 32'h19);
		cmp("irq", 32'h0, irq);
		wr(ADDR_MSTATE, 32'h19);
		pm.pin(4'b1001);
		tk(CS_SYS_RESET);
		pm.pin(4'b0000);
		rd(ADDR_SAVED_MS, 32'h18);
		wr(ADDR_MSTATE, 32'h19);
		pm.pin(4'b0101);
		tk(CS_MCHECK);
		pm.pin(4'b0000);
		rd(ADDR_SAVED_MS, 32'h18);
		wr(ADDR_MSTATE, 32'h18);
		pm.pin(4'b1100);
		tk(CS_SYS_RESET);
		tk(CS_MCHECK);
		pm.pin(4'b0000);
		wr(ADDR_MSTATE, 32'h10);
		pm.pin(4'b0100);
		repeat (8) @(negedge clk_sys_in);
		cmp("stop", 32'h1, cs);
		rd(ADDR_INFO, 32'h1);
		rd(ADDR_STATUS, 32'h43);
		pm.fault(CS_DATA_FAULT, 32'h0000_6000, 1, got);
		cmp("ack", 32'h0, got);
		end_sim;
	end
endmodule
